// ### logic/meter_dsp_pkg.sv
package meter_dsp_pkg;

  // ****************************************************************
  // Widths and sample layout
  // ****************************************************************
  localparam int SAMPLE_W = 20;
  localparam int POWER_W = 24;
  localparam int WORD_W = 40;
  localparam int LP_FRAC = 16;
  localparam int GAIN_FRAC = 12;
  localparam int PRODUCT_SHIFT = 16;

  // ****************************************************************
  // Waveform source selections
  // ****************************************************************
  localparam logic [1:0] SRC_POWER = 2'h0;
  localparam logic [1:0] SRC_COMBINED = 2'h1;
  localparam logic [1:0] SRC_CURRENT = 2'h2;
  localparam logic [1:0] SRC_VOLTAGE = 2'h3;

  // ****************************************************************
  // Phase trim and delay line
  // ****************************************************************
  localparam logic signed [7:0] TRIM_MIN = 8'h9E;
  localparam logic signed [7:0] TRIM_MAX = 8'h5C;
  localparam real MASTER_CLOCK_HZ = 3579545.0;
  localparam real TRIM_STEP_US = 1.12;
  localparam int TRIM_STEP_CLKS = 4;
  localparam int ADC_RATE_DIV = 128;
  localparam int UNITS_PER_SAMPLE = ADC_RATE_DIV / TRIM_STEP_CLKS;
  localparam logic [9:0] BASE_DELAY_UNITS = 10'h080;
  localparam int V_HIST_DEPTH = 8;
  localparam int I_HIST_DEPTH = 5;
  localparam int I_DELAY_TAP = 4;

  // ****************************************************************
  // Filters and scaling
  // ****************************************************************
  localparam real WAVE_LP_CUTOFF_HZ = 156.0;
  localparam real ADC_RATE_HZ = MASTER_CLOCK_HZ / ADC_RATE_DIV;
  localparam logic [15:0] WAVE_LP_COEF =
    16'(int'(2.0 * 3.14159265 * WAVE_LP_CUTOFF_HZ / ADC_RATE_HZ * 65536.0));
  localparam logic signed [23:0] POWER_MAX = 24'h7FFFFF;
  localparam logic signed [23:0] POWER_MIN = 24'h800000;
  localparam logic [2:0] DEC_CNT_RESET = 3'h0;

  typedef struct packed {
    logic signed [19:0] current;
    logic signed [19:0] voltage;
  } channel_pair_type;

  typedef struct packed {
    logic [1:0] source;
    logic [39:0] data;
  } wave_sample_type;

endpackage : meter_dsp_pkg

// ### logic/wave_skid_buffer.sv
`timescale 1ns/10ps
module wave_skid_buffer #(
  parameter int WIDTH = 42
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic head_valid_reg, head_valid_next;
  logic spare_valid_reg, spare_valid_next;
  logic [WIDTH-1:0] head_reg, head_next;
  logic [WIDTH-1:0] spare_reg, spare_next;

  // The head entry drives the output; the spare entry absorbs one word while stalled.
  always_comb begin
    head_valid_next = head_valid_reg;
    spare_valid_next = spare_valid_reg;
    head_next = head_reg;
    spare_next = spare_reg;
    if (head_valid_reg && out_ready) begin
      if (spare_valid_reg) begin
        head_next = spare_reg;
        spare_valid_next = 1'b0;
      end else begin
        head_valid_next = 1'b0;
      end
    end
    if (in_valid && !spare_valid_reg) begin
      if (!head_valid_next) begin
        head_next = in_data;
        head_valid_next = 1'b1;
      end else begin
        spare_next = in_data;
        spare_valid_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      head_valid_reg <= 1'b0;
      spare_valid_reg <= 1'b0;
      head_reg <= '0;
      spare_reg <= '0;
    end else begin
      head_valid_reg <= head_valid_next;
      spare_valid_reg <= spare_valid_next;
      head_reg <= head_next;
      spare_reg <= spare_next;
    end
  end

  assign in_ready = !spare_valid_reg;
  assign out_valid = head_valid_reg;
  assign out_data = head_reg;

endmodule : wave_skid_buffer

// ### logic/meter_wave_phase_power_dsp.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Combined source delivers one 40-bit word holding both channel samples.
// - Voltage samples keep the current channel's code scaling, no rescale.
// - Voltage source (11) waveform samples pass a single-pole 156 Hz lowpass first; combined words carry unfiltered voltage.
// - The multiplier takes the unfiltered voltage samples.
// - Two rate bits pick every 1st, 2nd, 4th or 8th sample.
// - Interrupt output goes low while a new sample waits.
// - With highpass off and zero trim both paths have equal delay.
// - Phase trim is signed 8-bit, clamped to 9Eh through 5Ch.
// - One trim unit shifts voltage delay by four master clocks.
// - Negative trim shortens voltage delay, giving a phase lead.
// - Power is the lowpassed product of current and voltage samples.
// - Gain trim 800h gives the smallest range, 7FFh the largest.
// - Twenty-bit current and voltage source samples are sign extended to 24 bits, low aligned.
// - Gain trim is signed 12-bit, scaling by one plus trim over 4096.
// - Source 00 routes active power into the waveform word.
module meter_wave_phase_power_dsp #(
  parameter int POWER_LP_SHIFT = 8,
  parameter int HPF_SHIFT = 10
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic adc_valid,
  input wire logic signed [19:0] current_sample,
  input wire logic signed [19:0] voltage_sample,
  input wire logic current_highpass_enable,
  input wire logic [7:0] phase_delay_trim,
  input wire logic [11:0] power_gain_trim,
  input wire logic [1:0] wave_source_select,
  input wire logic [1:0] sample_rate_select,
  input wire logic sample_irq_enable,
  input wire logic wave_ready,
  output logic wave_valid,
  output meter_dsp_pkg::wave_sample_type wave_sample,
  output logic signed [23:0] active_power,
  output logic active_power_valid,
  output logic irq_b,
  output logic wave_overrun
);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic signed [7:0] clamp_trim(input logic signed [7:0] raw);
    if (raw < meter_dsp_pkg::TRIM_MIN) begin
      return meter_dsp_pkg::TRIM_MIN;
    end else if (raw > meter_dsp_pkg::TRIM_MAX) begin
      return meter_dsp_pkg::TRIM_MAX;
    end
    return raw;
  endfunction : clamp_trim

  function automatic logic [2:0] rate_mask(input logic [1:0] sel);
    return 3'((4'h1 << sel) - 4'h1);
  endfunction : rate_mask

  // ****************************************************************
  // State
  // ****************************************************************
  logic signed [19:0] v_hist_reg [meter_dsp_pkg::V_HIST_DEPTH];
  logic signed [19:0] v_hist_next [meter_dsp_pkg::V_HIST_DEPTH];
  logic signed [19:0] i_hist_reg [meter_dsp_pkg::I_HIST_DEPTH];
  logic signed [19:0] i_hist_next [meter_dsp_pkg::I_HIST_DEPTH];
  logic signed [35:0] hpf_dc_reg, hpf_dc_next;
  logic s1_reg, s1_next, s2_reg, s2_next, s3_reg, s3_next, s4_reg, s4_next;
  logic signed [19:0] v_al_reg, v_al_next, i_al_reg, i_al_next;
  logic signed [23:0] prod_reg, prod_next;
  logic signed [35:0] wave_lp_reg, wave_lp_next;
  logic signed [39:0] power_lp_reg, power_lp_next;
  logic signed [23:0] active_power_reg, active_power_next;
  logic ap_valid_reg, ap_valid_next;
  logic [2:0] dec_cnt_reg, dec_cnt_next;
  logic pend_valid_reg, pend_valid_next;
  meter_dsp_pkg::wave_sample_type pend_reg, pend_next;
  logic overrun_reg, overrun_next, irq_b_reg, irq_b_next;

  logic signed [19:0] hp_out;
  logic signed [7:0] trim;
  logic [9:0] delay_units;
  logic [2:0] tap;
  logic [4:0] frac;
  logic signed [27:0] interp;
  logic signed [39:0] product;
  logic signed [36:0] wave_diff;
  logic signed [53:0] wave_step;
  logic signed [23:0] pl_int;
  logic signed [35:0] gain_prod;
  logic signed [25:0] gained;
  logic emit;
  meter_dsp_pkg::channel_pair_type pair;
  logic [39:0] word;
  logic buf_in_ready, buf_out_valid;

  // ****************************************************************
  // Datapath next state
  // ****************************************************************
  always_comb begin
    v_hist_next = v_hist_reg;
    i_hist_next = i_hist_reg;
    hpf_dc_next = hpf_dc_reg;
    v_al_next = v_al_reg;
    i_al_next = i_al_reg;
    prod_next = prod_reg;
    wave_lp_next = wave_lp_reg;
    power_lp_next = power_lp_reg;
    active_power_next = active_power_reg;
    s1_next = adc_valid;
    s2_next = s1_reg;
    s3_next = s2_reg;
    s4_next = s3_reg;
    // Highpass sits in the same stage as the raw path, so delay is unchanged.
    hp_out = current_sample;
    if (current_highpass_enable) begin
      hp_out = 20'(current_sample - hpf_dc_reg[35:16]);
    end
    if (adc_valid) begin
      for (int k = 1; k < meter_dsp_pkg::V_HIST_DEPTH; k++) begin
        v_hist_next[k] = v_hist_reg[k-1];
      end
      for (int k = 1; k < meter_dsp_pkg::I_HIST_DEPTH; k++) begin
        i_hist_next[k] = i_hist_reg[k-1];
      end
      v_hist_next[0] = voltage_sample;
      i_hist_next[0] = hp_out;
      if (current_highpass_enable) begin
        hpf_dc_next = 36'(hpf_dc_reg +
          (($signed({current_sample, 16'h0000}) - hpf_dc_reg) >>> HPF_SHIFT));
      end
    end
    // Fractional delay: 32 trim units per sample, linear interpolation between taps.
    trim = clamp_trim(phase_delay_trim);
    delay_units = 10'(meter_dsp_pkg::BASE_DELAY_UNITS + {{2{trim[7]}}, trim});
    tap = delay_units[7:5];
    frac = delay_units[4:0];
    // The near tap weight reaches 32 at zero fraction, so it needs six bits.
    interp = 28'(v_hist_reg[tap] * $signed({1'b0, 6'(6'h20 - {1'b0, frac})}))
      + 28'(v_hist_reg[3'(tap + 3'h1)] * $signed({2'b00, frac}));
    if (s1_reg) begin
      v_al_next = interp[24:5];
      i_al_next = i_hist_reg[meter_dsp_pkg::I_DELAY_TAP];
    end
    product = 40'(v_al_reg * i_al_reg);
    wave_diff = 37'($signed({v_al_reg, 16'h0000}) - wave_lp_reg);
    wave_step = 54'(wave_diff * $signed({1'b0, meter_dsp_pkg::WAVE_LP_COEF}));
    if (s2_reg) begin
      prod_next = 24'(product >>> meter_dsp_pkg::PRODUCT_SHIFT);
      wave_lp_next = 36'(wave_lp_reg + (wave_step >>> meter_dsp_pkg::LP_FRAC));
    end
    if (s3_reg) begin
      power_lp_next = 40'(power_lp_reg +
        (($signed({prod_reg, 16'h0000}) - power_lp_reg) >>> POWER_LP_SHIFT));
    end
    pl_int = power_lp_reg[39:16];
    gain_prod = 36'(pl_int * $signed(power_gain_trim));
    gained = 26'(pl_int + (gain_prod >>> meter_dsp_pkg::GAIN_FRAC));
    if (s4_reg) begin
      if (gained > 26'(meter_dsp_pkg::POWER_MAX)) begin
        active_power_next = meter_dsp_pkg::POWER_MAX;
      end else if (gained < 26'(meter_dsp_pkg::POWER_MIN)) begin
        active_power_next = meter_dsp_pkg::POWER_MIN;
      end else begin
        active_power_next = gained[23:0];
      end
    end
    ap_valid_next = s4_reg;
  end

  // ****************************************************************
  // Waveform sample selection and delivery next state
  // ****************************************************************
  always_comb begin
    dec_cnt_next = dec_cnt_reg;
    pend_valid_next = pend_valid_reg;
    pend_next = pend_reg;
    overrun_next = overrun_reg && sample_irq_enable;
    pair.current = i_al_reg;
    pair.voltage = v_al_reg;
    case (wave_source_select)
      meter_dsp_pkg::SRC_POWER: word = {16'h0000, active_power_next};
      meter_dsp_pkg::SRC_COMBINED: word = pair;
      meter_dsp_pkg::SRC_CURRENT: word = {16'h0000, {4{i_al_reg[19]}}, i_al_reg};
      meter_dsp_pkg::SRC_VOLTAGE: word = {16'h0000, {4{wave_lp_reg[35]}}, wave_lp_reg[35:16]};
      default: word = 40'h0000000000;
    endcase
    // Sampling only runs while the host keeps the interrupt enable set.
    emit = s4_reg && sample_irq_enable
      && ((dec_cnt_reg & rate_mask(sample_rate_select)) == 3'h0);
    if (s4_reg) begin
      dec_cnt_next = 3'(dec_cnt_reg + 3'h1);
    end
    if (pend_valid_reg && buf_in_ready) begin
      pend_valid_next = 1'b0;
    end
    if (emit) begin
      if (pend_valid_reg && !buf_in_ready) begin
        overrun_next = 1'b1;
      end
      pend_valid_next = 1'b1;
      pend_next.source = wave_source_select;
      pend_next.data = word;
    end
    irq_b_next = !(buf_out_valid && sample_irq_enable);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int k = 0; k < meter_dsp_pkg::V_HIST_DEPTH; k++) begin
        v_hist_reg[k] <= '0;
      end
      for (int k = 0; k < meter_dsp_pkg::I_HIST_DEPTH; k++) begin
        i_hist_reg[k] <= '0;
      end
      hpf_dc_reg <= '0;
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      s4_reg <= 1'b0;
      v_al_reg <= '0;
      i_al_reg <= '0;
      prod_reg <= '0;
      wave_lp_reg <= '0;
      power_lp_reg <= '0;
      active_power_reg <= '0;
      ap_valid_reg <= 1'b0;
      dec_cnt_reg <= meter_dsp_pkg::DEC_CNT_RESET;
      pend_valid_reg <= 1'b0;
      pend_reg <= '0;
      overrun_reg <= 1'b0;
      irq_b_reg <= 1'b1;
    end else begin
      v_hist_reg <= v_hist_next;
      i_hist_reg <= i_hist_next;
      hpf_dc_reg <= hpf_dc_next;
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      s4_reg <= s4_next;
      v_al_reg <= v_al_next;
      i_al_reg <= i_al_next;
      prod_reg <= prod_next;
      wave_lp_reg <= wave_lp_next;
      power_lp_reg <= power_lp_next;
      active_power_reg <= active_power_next;
      ap_valid_reg <= ap_valid_next;
      dec_cnt_reg <= dec_cnt_next;
      pend_valid_reg <= pend_valid_next;
      pend_reg <= pend_next;
      overrun_reg <= overrun_next;
      irq_b_reg <= irq_b_next;
    end
  end

  wave_skid_buffer #(
    .WIDTH($bits(meter_dsp_pkg::wave_sample_type))
  ) wave_buffer (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .in_valid(pend_valid_reg),
    .in_ready(buf_in_ready),
    .in_data(pend_reg),
    .out_valid(buf_out_valid),
    .out_ready(wave_ready),
    .out_data(wave_sample)
  );

  assign wave_valid = buf_out_valid;
  assign active_power = active_power_reg;
  assign active_power_valid = ap_valid_reg;
  assign irq_b = irq_b_reg;
  assign wave_overrun = overrun_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_trim_in_range: assert property (trim >= meter_dsp_pkg::TRIM_MIN
    && trim <= meter_dsp_pkg::TRIM_MAX) else $error("trim out of range");
  a_zero_trim_match: assert property (trim == 8'sh00 |-> tap == 3'h4 && frac == 5'h00)
    else $error("zero trim not matched");
  a_negative_advance: assert property (trim < 8'sh00 |-> delay_units < 10'h080)
    else $error("negative trim not advancing");
  a_trim_unit_step: assert property (trim == 8'shFC |-> tap == 3'h3 && frac == 5'h1C)
    else $error("trim unit step wrong");
  a_product_raw: assert property (s2_reg |=> prod_reg == 24'($past(product) >>> 16))
    else $error("product not from raw samples");
  a_power_pipe: assert property (s1_reg |-> ##4 ap_valid_reg)
    else $error("power result missing");
  a_gain_unity: assert property (s4_reg && power_gain_trim == 12'h000 |=>
    active_power_reg == $past(pl_int)) else $error("zero gain trim changed power");
  a_combined_layout: assert property (emit && wave_source_select == meter_dsp_pkg::SRC_COMBINED
    |=> pend_reg.data == {$past(i_al_reg), $past(v_al_reg)}) else $error("combined layout");
  a_sign_extend: assert property (emit && wave_source_select == meter_dsp_pkg::SRC_CURRENT
    |=> pend_reg.data[23:19] == {5{pend_reg.data[19]}}) else $error("no sign extension");
  a_rate_slowest: assert property (emit && sample_rate_select == 2'h3
    |-> dec_cnt_reg == 3'h0) else $error("rate decimation wrong");
  a_irq_follows: assert property (buf_out_valid && sample_irq_enable |=> !irq_b)
    else $error("irq not asserted");
  a_pending_held: assert property (pend_valid_reg && !buf_in_ready && !emit
    |=> pend_valid_reg && $stable(pend_reg)) else $error("pending sample lost");

  c_combined_emit: cover property (emit && wave_source_select == meter_dsp_pkg::SRC_COMBINED);
  c_voltage_emit: cover property (emit && wave_source_select == meter_dsp_pkg::SRC_VOLTAGE);
  c_buffer_full: cover property (pend_valid_reg && !buf_in_ready);
  c_negative_trim: cover property (s1_reg && trim < 8'sh00);

endmodule : meter_wave_phase_power_dsp

// ### sim/wave_reader.sv
`timescale 1ns/10ps
module wave_reader (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wave_valid,
  input wire meter_dsp_pkg::wave_sample_type wave_sample,
  input wire logic stall,
  output logic wave_ready
);
  logic [39:0] words[$];

  initial wave_ready = 1'b0;

  // ****************************************************************
  // Reader side of the sample stream
  // ****************************************************************
  // Ready only moves after a falling edge, so a stall never cuts a word in half.
  always @(negedge clk_sys) begin
    wave_ready <= ~stall;
  end

  // Every taken word is kept in arrival order for the bench to inspect.
  always @(posedge clk_sys) begin
    if (rst_b && wave_valid && wave_ready) begin
      words.push_back(wave_sample.data);
    end
  end
endmodule : wave_reader

// ### sim/meter_wave_phase_power_dsp_test.sv
`timescale 1ns/10ps
module meter_wave_phase_power_dsp_test;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic adc_valid = 1'b0;
  logic signed [19:0] current_sample = 20'h00000;
  logic signed [19:0] voltage_sample = 20'h00000;
  logic current_highpass_enable = 1'b0;
  logic [7:0] phase_delay_trim = 8'h00;
  logic [11:0] power_gain_trim = 12'h000;
  logic [1:0] wave_source_select = 2'h0;
  logic [1:0] sample_rate_select = 2'h0;
  logic sample_irq_enable = 1'b0;
  logic stall = 1'b0;
  logic wave_ready;
  logic wave_valid;
  meter_dsp_pkg::wave_sample_type wave_sample;
  logic signed [23:0] active_power;
  logic active_power_valid;
  logic irq_b;
  logic wave_overrun;
  int n_errors = 0;
  int n_checks = 0;
  int pulses = 0;

  always #4 clk_sys = ~clk_sys;

  meter_wave_phase_power_dsp #(.POWER_LP_SHIFT(2), .HPF_SHIFT(10)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .adc_valid(adc_valid),
    .current_sample(current_sample), .voltage_sample(voltage_sample),
    .current_highpass_enable(current_highpass_enable),
    .phase_delay_trim(phase_delay_trim), .power_gain_trim(power_gain_trim),
    .wave_source_select(wave_source_select), .sample_rate_select(sample_rate_select),
    .sample_irq_enable(sample_irq_enable), .wave_ready(wave_ready),
    .wave_valid(wave_valid), .wave_sample(wave_sample), .active_power(active_power),
    .active_power_valid(active_power_valid), .irq_b(irq_b), .wave_overrun(wave_overrun)
  );

  wave_reader reader (
    .clk_sys(clk_sys), .rst_b(rst_b), .wave_valid(wave_valid),
    .wave_sample(wave_sample), .stall(stall), .wave_ready(wave_ready)
  );

  always @(posedge clk_sys) begin
    if (active_power_valid === 1'b1) begin
      pulses++;
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  function automatic logic near(input logic [23:0] a, input int b, input int tol);
    if ($isunknown(a)) begin
      return 1'bx;
    end
    return ((int'($signed(a)) - b) <= tol) && ((b - int'($signed(a))) <= tol);
  endfunction : near

  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Samples are eight cycles apart, then the pipeline is left to drain.
  task automatic feed(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      adc_valid = 1'b1;
      @(negedge clk_sys);
      adc_valid = 1'b0;
      repeat (6) @(negedge clk_sys);
    end
    repeat (12) @(negedge clk_sys);
  endtask : feed

  task automatic do_reset(input logic [1:0] src);
    rst_b = 1'b0;
    wave_source_select = src;
    sample_irq_enable = 1'b1;
    repeat (10) @(negedge clk_sys);
    check({wave_valid, irq_b, active_power_valid, wave_overrun}, 4'h4, "reset outputs");
    check(active_power, 24'h000000, "reset power");
    repeat (10) @(negedge clk_sys);
    rst_b = 1'b1;
    @(negedge clk_sys);
  endtask : do_reset

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_power;
    int p0;
    do_reset(meter_dsp_pkg::SRC_POWER);
    current_sample = 20'h10000;
    voltage_sample = 20'h28000;
    feed(60);
    check(near(active_power, 163840, 4), 1, "power");
    check(near(reader.words[$][23:0], 163840, 4), 1, "power word");
    power_gain_trim = 12'h7FF;
    feed(2);
    check(near(active_power, 245720, 4), 1, "gain max");
    power_gain_trim = 12'h800;
    feed(2);
    check(near(active_power, 81920, 4), 1, "gain min");
    power_gain_trim = 12'h000;
    p0 = pulses;
    for (int k = 0; k < 8; k++) begin
      phase_delay_trim = 8'hFC + 8'(k * 8'h1F);
      feed(1);
    end
    check(pulses - p0, 8, "pulses during trim change");
    check(near(active_power, 163840, 4), 1, "power after trim");
    phase_delay_trim = 8'h00;
  endtask : test_power

  task automatic test_voltage;
    logic [39:0] w;
    do_reset(meter_dsp_pkg::SRC_VOLTAGE);
    current_sample = 20'h10000;
    voltage_sample = 20'hD7AE1;
    feed(50);
    check(near(active_power, -165151, 8), 1, "unfiltered power");
    w = reader.words[$];
    check($signed(w[23:0]) > -148636, 1, "wave lowpass lag");
    feed(300);
    w = reader.words[$];
    check(near(w[23:0], -165151, 32), 1, "wave settled");
    check({w[39:20]}, 20'h0000F, "sign extension");
  endtask : test_voltage

  task automatic test_combined;
    logic [39:0] w;
    do_reset(meter_dsp_pkg::SRC_COMBINED);
    current_sample = 20'h12345;
    voltage_sample = 20'hD7AE1;
    feed(8);
    check(reader.words[$], {20'h12345, 20'hD7AE1}, "combined word");
    current_sample = 20'h2851F;
    voltage_sample = 20'h0ABCD;
    feed(8);
    check(reader.words[$], {20'h2851F, 20'h0ABCD}, "combined layout");
    current_highpass_enable = 1'b1;
    feed(8);
    w = reader.words[$];
    check(w[19:0], 20'h0ABCD, "voltage untouched by highpass");
    check(w[39:20] < 20'h2851F && w[39:20] > 20'h28010, 1, "highpass trims current");
    current_highpass_enable = 1'b0;
  endtask : test_combined

  task automatic test_rates;
    int s0;
    do_reset(meter_dsp_pkg::SRC_CURRENT);
    for (int k = 0; k < 4; k++) begin
      sample_rate_select = 2'(k);
      s0 = reader.words.size();
      feed(16);
      check(reader.words.size() - s0, 16 >> k, "words per rate");
    end
    sample_rate_select = 2'h0;
  endtask : test_rates

  task automatic test_stall;
    int s0;
    stall = 1'b1;
    feed(1);
    check({wave_valid, irq_b}, 2'h2, "irq low while waiting");
    check(wave_sample.source, meter_dsp_pkg::SRC_CURRENT, "source tag");
    feed(3);
    check(wave_overrun, 1'b1, "overrun when full");
    s0 = reader.words.size();
    stall = 1'b0;
    repeat (8) @(negedge clk_sys);
    check(reader.words.size() - s0, 3, "words kept while stalled");
    check({wave_valid, irq_b}, 2'h1, "irq high when drained");
    sample_irq_enable = 1'b0;
    s0 = reader.words.size();
    feed(4);
    check(wave_overrun, 1'b0, "overrun cleared");
    check(reader.words.size() - s0, 0, "no words when disabled");
  endtask : test_stall

  initial begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    test_power();
    test_voltage();
    test_combined();
    test_rates();
    test_stall();
    wrap_up();
  end
endmodule : meter_wave_phase_power_dsp_test
